// ===== cbu_compare_flags.sv
/*
 subtract-style compare producing temporary condition flags.
 assumes operands are already selected; flags never leave the unit.
*/
`timescale 1ns/1ps
module cbu_compare_flags
    import cbu_pkg::*;
(
    // operands
    input wire logic [63:0] first_in,
    input wire logic [63:0] second_in,
    input wire logic wide_in,
    // temporary flags
    output cc_flags_type flags_out
);
    logic [32:0] diff_narrow;
    logic [64:0] diff_wide;

    assign diff_narrow = {1'b0, first_in[NARROW_MSB:0]} - {1'b0, second_in[NARROW_MSB:0]};
    assign diff_wide = {1'b0, first_in} - {1'b0, second_in};

    // flags only feed the branch decision, no architectural write
    always_comb begin
        if (wide_in) begin
            flags_out.neg = diff_wide[WIDE_MSB];
            flags_out.zero = (diff_wide[WIDE_MSB:0] == 64'h0);
            flags_out.ovf = (first_in[WIDE_MSB] != second_in[WIDE_MSB])
                && (diff_wide[WIDE_MSB] != first_in[WIDE_MSB]);
            flags_out.borrow = diff_wide[WIDE_MSB+1];
        end else begin
            flags_out.neg = diff_narrow[NARROW_MSB];
            flags_out.zero = (diff_narrow[NARROW_MSB:0] == 32'h0);
            flags_out.ovf = (first_in[NARROW_MSB] != second_in[NARROW_MSB])
                && (diff_narrow[NARROW_MSB] != first_in[NARROW_MSB]);
            flags_out.borrow = diff_narrow[NARROW_MSB+1];
        end
    end

endmodule : cbu_compare_flags

// ===== cbu_condition_eval.sv
/*
 evaluates a 4-bit branch condition against temporary flags.
 assumes the same encoding as the other conditional branches.
*/
`timescale 1ns/1ps
module cbu_condition_eval
    import cbu_pkg::*;
(
    // inputs
    input wire logic [3:0] condition_in,
    input cc_flags_type flags_in,
    // result
    output logic true_out
);
    function automatic logic cond_holds(input logic [3:0] c, input cc_flags_type f);
        logic r;
        r = 1'b0;
        case (c)
            COND_NEVER: r = 1'b0;
            COND_EQ: r = f.zero;
            COND_LE: r = f.zero | (f.neg ^ f.ovf);
            COND_LT: r = f.neg ^ f.ovf;
            COND_LEU: r = f.borrow | f.zero;
            COND_CS: r = f.borrow;
            COND_NEG: r = f.neg;
            COND_VS: r = f.ovf;
            COND_ALWAYS: r = 1'b1;
            COND_NE: r = ~f.zero;
            COND_GT: r = ~(f.zero | (f.neg ^ f.ovf));
            COND_GE: r = ~(f.neg ^ f.ovf);
            COND_GTU: r = ~(f.borrow | f.zero);
            COND_CC: r = ~f.borrow;
            COND_POS: r = ~f.neg;
            COND_VC: r = ~f.ovf;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : cond_holds

    assign true_out = cond_holds(condition_in, flags_in);

endmodule : cbu_condition_eval

// ===== cbu_pkg.sv
/*
 package for the compare-and-branch unit: instruction fields, temporary
 flags, condition codes, register map and event bits.
 assumes a 64-bit core and a 32-bit AXI4-Lite register bus.
*/
package cbu_pkg;

    typedef struct packed {
        logic [4:0] first_source_register;
        logic [4:0] second_source_register;
        logic [1:0] displacement_high_field;
        logic [7:0] displacement_low_field;
        logic condition_high_subfield;
        logic [2:0] condition_low_subfield;
        logic operand_width_select;
        logic immediate_select;
        logic [4:0] short_signed_immediate;
    } branch_fields_type;

    typedef struct packed {
        logic neg;
        logic zero;
        logic ovf;
        logic borrow;
    } cc_flags_type;

    // condition encodings shared with the other conditional branches
    localparam logic [3:0] COND_NEVER = 4'h0;
    localparam logic [3:0] COND_EQ = 4'h1;
    localparam logic [3:0] COND_LE = 4'h2;
    localparam logic [3:0] COND_LT = 4'h3;
    localparam logic [3:0] COND_LEU = 4'h4;
    localparam logic [3:0] COND_CS = 4'h5;
    localparam logic [3:0] COND_NEG = 4'h6;
    localparam logic [3:0] COND_VS = 4'h7;
    localparam logic [3:0] COND_ALWAYS = 4'h8;
    localparam logic [3:0] COND_NE = 4'h9;
    localparam logic [3:0] COND_GT = 4'hA;
    localparam logic [3:0] COND_GE = 4'hB;
    localparam logic [3:0] COND_GTU = 4'hC;
    localparam logic [3:0] COND_CC = 4'hD;
    localparam logic [3:0] COND_POS = 4'hE;
    localparam logic [3:0] COND_VC = 4'hF;
    localparam logic [2:0] COND_LO_RESERVED = 3'h0;

    localparam int BRANCH_WORD_SHIFT = 2;
    localparam int NARROW_MSB = 31;
    localparam int WIDE_MSB = 63;

    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_LEVEL_SELECT = 8'h0C;
    localparam logic [7:0] OFS_SAVED_PC_LO = 8'h10;
    localparam logic [7:0] OFS_SAVED_PC_HI = 8'h14;
    localparam logic [7:0] OFS_SAVED_NPC_LO = 8'h18;
    localparam logic [7:0] OFS_SAVED_NPC_HI = 8'h1C;

    localparam int CTRL_TCT_BIT = 0;
    localparam int EVENT_W = 3;
    localparam int EV_ILLEGAL = 0;
    localparam int EV_CTT = 1;
    localparam int EV_TAKEN = 2;
    localparam logic [EVENT_W-1:0] EVENT_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : cbu_pkg

// ===== compare_branch_unit.sv
/*
 compare-and-branch execution unit with AXI4-Lite control/status.
 assumes fetch and trap logic on core_clk_in; operands valid with issue.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
// How it works
// - false comparison leaves the pc alone; next sequential instruction runs.
// - true comparison branches at once to pc plus four times displacement.
// - displacement is a 10-bit signed word offset, -512 to +511 words.
// - first operand is first register; second is register or signed immediate.
// - width select low compares 32 bits, high compares all 64 bits.
// - compare flags are temporary; the architectural condition codes stay untouched.
// - non-delayed transfer: no delay slot, annul bit or prediction hint.
// - condition subfields decode exactly like other conditional branches.
// - reserved low condition subfield 000 raises illegal instruction.
// - with transfer trapping enabled, a taken branch traps instead.
// - that trap saves instruction pc and prior next pc at trap level.
// - equal condition on identical registers always branches, both widths.
`timescale 1ns/1ps
module compare_branch_unit
    import cbu_pkg::*;
#(
    parameter int TRAP_LEVELS = 8,
    parameter bit TCT_IMPLEMENTED = 1'b1
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // issue
    input wire logic issue_valid_in,
    input branch_fields_type fields_in,
    input wire logic [63:0] pc_in,
    input wire logic [63:0] npc_in,
    input wire logic [63:0] first_operand_in,
    input wire logic [63:0] second_operand_in,
    input wire logic [$clog2(TRAP_LEVELS)-1:0] trap_level_in,
    // outcome to fetch and trap logic
    output logic redirect_valid_out,
    output logic [63:0] redirect_target_out,
    output logic sequential_valid_out,
    output logic illegal_trap_out,
    output logic ctt_trap_out,
    output logic [63:0] trap_saved_pc_out,
    output logic [63:0] trap_saved_next_pc_out,
    output logic [$clog2(TRAP_LEVELS)-1:0] trap_level_out,
    output logic irq_out,
    // axi4-lite slave
    input wire logic axi_awvalid_in,
    input wire logic [ADDR_W-1:0] axi_awaddr_in,
    output logic axi_awready_out,
    input wire logic axi_wvalid_in,
    input wire logic [31:0] axi_wdata_in,
    input wire logic [3:0] axi_wstrb_in,
    output logic axi_wready_out,
    output logic axi_bvalid_out,
    output logic [1:0] axi_bresp_out,
    input wire logic axi_bready_in,
    input wire logic axi_arvalid_in,
    input wire logic [ADDR_W-1:0] axi_araddr_in,
    output logic axi_arready_out,
    output logic axi_rvalid_out,
    output logic [31:0] axi_rdata_out,
    output logic [1:0] axi_rresp_out,
    input wire logic axi_rready_in
);
    localparam int TL_W = $clog2(TRAP_LEVELS);

    // refused at elaboration: the level index must address every entry
    if (TRAP_LEVELS < 2 || (1 << TL_W) != TRAP_LEVELS) begin : g_bad_levels
        $error("TRAP_LEVELS must be a power of two, at least 2");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return a inside {OFS_CONTROL, OFS_STATUS, OFS_MASK, OFS_LEVEL_SELECT,
            OFS_SAVED_PC_LO, OFS_SAVED_PC_HI, OFS_SAVED_NPC_LO, OFS_SAVED_NPC_HI};
    endfunction : is_mapped

    // decision path
    logic [63:0] operand_b;
    logic [63:0] disp_bytes;
    logic [63:0] target;
    cc_flags_type flags;
    logic cond_true;
    logic illegal;
    logic tct_active;
    logic trap_ctt;
    logic taken;
    logic tct_enable_q;

    always_comb begin
        operand_b = fields_in.immediate_select
            ? 64'($signed(fields_in.short_signed_immediate))
            : second_operand_in;
    end

    // 10-bit word offset, scaled to bytes
    assign disp_bytes = 64'($signed({fields_in.displacement_high_field,
        fields_in.displacement_low_field})) << BRANCH_WORD_SHIFT;
    assign target = pc_in + disp_bytes;

    cbu_compare_flags u_compare (
        .first_in(first_operand_in),
        .second_in(operand_b),
        .wide_in(fields_in.operand_width_select),
        .flags_out(flags)
    );

    cbu_condition_eval u_condition (
        .condition_in({fields_in.condition_high_subfield, fields_in.condition_low_subfield}),
        .flags_in(flags),
        .true_out(cond_true)
    );

    assign illegal = (fields_in.condition_low_subfield == COND_LO_RESERVED);
    assign tct_active = TCT_IMPLEMENTED && tct_enable_q;
    assign trap_ctt = !illegal && cond_true && tct_active;
    assign taken = !illegal && cond_true && !tct_active;

    // outcome registered once per issue; no slot, no annul, no hint
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            redirect_valid_out <= 1'b0;
            redirect_target_out <= 64'h0;
            sequential_valid_out <= 1'b0;
            illegal_trap_out <= 1'b0;
            ctt_trap_out <= 1'b0;
        end else begin
            redirect_valid_out <= issue_valid_in && taken;
            if (issue_valid_in && taken) begin
                redirect_target_out <= target;
            end
            sequential_valid_out <= issue_valid_in && !illegal && !cond_true;
            illegal_trap_out <= issue_valid_in && illegal;
            ctt_trap_out <= issue_valid_in && trap_ctt;
        end
    end

    // saved pc pair per trap level, readable over the bus
    logic [63:0] saved_pc_mem [TRAP_LEVELS];
    logic [63:0] saved_npc_mem [TRAP_LEVELS];

    always_ff @(posedge core_clk_in) begin
        if (issue_valid_in && trap_ctt) begin
            saved_pc_mem[trap_level_in] <= pc_in;
            saved_npc_mem[trap_level_in] <= npc_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trap_saved_pc_out <= 64'h0;
            trap_saved_next_pc_out <= 64'h0;
            trap_level_out <= '0;
        end else if (issue_valid_in && trap_ctt) begin
            trap_saved_pc_out <= pc_in;
            trap_saved_next_pc_out <= npc_in;
            trap_level_out <= trap_level_in;
        end
    end

    // register file
    logic [EVENT_W-1:0] status_q;
    logic [EVENT_W-1:0] status_d;
    logic [EVENT_W-1:0] mask_q;
    logic [TL_W-1:0] level_select_q;
    logic [EVENT_W-1:0] events;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    logic do_write;
    logic [31:0] read_word;

    assign events[EV_ILLEGAL] = illegal_trap_out;
    assign events[EV_CTT] = ctt_trap_out;
    assign events[EV_TAKEN] = redirect_valid_out;
    assign do_write = !axi_awready_out && !axi_wready_out && !axi_bvalid_out;

    // set beats a same-cycle write-one clear
    always_comb begin
        status_d = status_q;
        if (do_write && wstrb0_q && awaddr_q == OFS_STATUS) begin
            status_d = status_q & ~wdata_q[EVENT_W-1:0];
        end
        status_d = status_d | events;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_q <= EVENT_RESET;
            irq_out <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_out <= |(status_d & mask_q);
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tct_enable_q <= 1'b0;
            mask_q <= EVENT_RESET;
            level_select_q <= '0;
        end else if (do_write && wstrb0_q) begin
            case (awaddr_q)
                OFS_CONTROL: tct_enable_q <= wdata_q[CTRL_TCT_BIT];
                OFS_MASK: mask_q <= wdata_q[EVENT_W-1:0];
                OFS_LEVEL_SELECT: level_select_q <= wdata_q[TL_W-1:0];
                default: ;
            endcase
        end
    end

    // write channel: address and data in either order
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            axi_awready_out <= 1'b1;
            axi_wready_out <= 1'b1;
            axi_bvalid_out <= 1'b0;
            axi_bresp_out <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb0_q <= 1'b0;
        end else begin
            if (axi_awvalid_in && axi_awready_out) begin
                axi_awready_out <= 1'b0;
                awaddr_q <= axi_awaddr_in;
            end
            if (axi_wvalid_in && axi_wready_out) begin
                axi_wready_out <= 1'b0;
                wdata_q <= axi_wdata_in;
                wstrb0_q <= axi_wstrb_in[0];
            end
            if (do_write) begin
                axi_bvalid_out <= 1'b1;
                axi_bresp_out <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (axi_bvalid_out && axi_bready_in) begin
                axi_bvalid_out <= 1'b0;
                axi_awready_out <= 1'b1;
                axi_wready_out <= 1'b1;
            end
        end
    end

    always_comb begin
        case (axi_araddr_in)
            OFS_CONTROL: read_word = 32'(tct_enable_q);
            OFS_STATUS: read_word = 32'(status_q);
            OFS_MASK: read_word = 32'(mask_q);
            OFS_LEVEL_SELECT: read_word = 32'(level_select_q);
            OFS_SAVED_PC_LO: read_word = saved_pc_mem[level_select_q][31:0];
            OFS_SAVED_PC_HI: read_word = saved_pc_mem[level_select_q][63:32];
            OFS_SAVED_NPC_LO: read_word = saved_npc_mem[level_select_q][31:0];
            OFS_SAVED_NPC_HI: read_word = saved_npc_mem[level_select_q][63:32];
            default: read_word = 32'h0;
        endcase
    end

    // read channel: one outstanding read
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            axi_arready_out <= 1'b1;
            axi_rvalid_out <= 1'b0;
            axi_rdata_out <= 32'h0;
            axi_rresp_out <= RESP_OKAY;
        end else if (axi_arvalid_in && axi_arready_out) begin
            axi_arready_out <= 1'b0;
            axi_rvalid_out <= 1'b1;
            axi_rdata_out <= read_word;
            axi_rresp_out <= is_mapped(axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
        end else if (axi_rvalid_out && axi_rready_in) begin
            axi_rvalid_out <= 1'b0;
            axi_arready_out <= 1'b1;
        end
    end

    // checks
    localparam int DISP_MIN_BYTES = -2048;
    localparam int DISP_MAX_BYTES = 2044;
    logic eq_plain;
    assign eq_plain = issue_valid_in && !illegal && !tct_active
        && {fields_in.condition_high_subfield, fields_in.condition_low_subfield} == COND_EQ;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);

    sequence s_taken_issue;
        issue_valid_in && taken;
    endsequence
    sequence s_redirect;
        redirect_valid_out && !sequential_valid_out && !ctt_trap_out;
    endsequence

    a_not_taken_seq: assert property (issue_valid_in && !illegal && !cond_true
        |=> sequential_valid_out && !redirect_valid_out) else $error("not-taken redirected");
    a_taken_target: assert property (s_taken_issue |=> s_redirect
        ##0 redirect_target_out == $past(pc_in) + $past(disp_bytes)) else $error("bad target");
    a_disp_range: assert property (redirect_valid_out
        |-> $signed(redirect_target_out - $past(pc_in)) >= DISP_MIN_BYTES
        && $signed(redirect_target_out - $past(pc_in)) <= DISP_MAX_BYTES) else $error("range");
    a_imm_zero_eq: assert property (eq_plain && fields_in.immediate_select
        && fields_in.short_signed_immediate == 5'h0 && first_operand_in == 64'h0
        |=> redirect_valid_out) else $error("immediate compare");
    a_narrow_eq: assert property (eq_plain && !fields_in.operand_width_select && !fields_in.immediate_select
        && first_operand_in[31:0] == second_operand_in[31:0] |=> redirect_valid_out)
        else $error("narrow compare");
    a_no_slot: assert property (redirect_valid_out |-> $past(issue_valid_in)
        ##1 (redirect_valid_out -> $past(issue_valid_in))) else $error("delayed redirect");
    a_never_cond: assert property (issue_valid_in && {fields_in.condition_high_subfield,
        fields_in.condition_low_subfield} == COND_NEVER |=> !redirect_valid_out) else $error("never");
    a_reserved_ill: assert property (issue_valid_in && illegal |=> illegal_trap_out
        && !redirect_valid_out && !sequential_valid_out) else $error("reserved");
    a_ctt_trap: assert property (issue_valid_in && !illegal && cond_true && tct_active
        |=> ctt_trap_out && !redirect_valid_out) else $error("ctt trap");
    a_ctt_save: assert property (ctt_trap_out |-> trap_saved_pc_out == $past(pc_in)
        && trap_saved_next_pc_out == $past(npc_in)) else $error("saved pcs");
    a_same_reg_eq: assert property (eq_plain && !fields_in.immediate_select
        && fields_in.first_source_register == fields_in.second_source_register
        && first_operand_in == second_operand_in |=> redirect_valid_out) else $error("self equal");
    a_one_outcome: assert property ($onehot0({redirect_valid_out, sequential_valid_out,
        illegal_trap_out, ctt_trap_out})) else $error("two outcomes");

endmodule : compare_branch_unit

// ===== fetch_trap_model.sv
/*
 fetch and trap sequencing model facing the compare-branch unit.
 assumes one outcome pulse per issued instruction on core_clk_in.
*/
`timescale 1ns/1ps
module fetch_trap_model #(
    parameter logic [63:0] START_PC = 64'h1000,
    parameter logic [63:0] TRAP_VECTOR = 64'h4000
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // outcome from the unit
    input wire logic redirect_valid_in,
    input wire logic [63:0] redirect_target_in,
    input wire logic sequential_valid_in,
    input wire logic trap_in,
    // program counters
    output logic [63:0] pc_out,
    output logic [63:0] npc_out
);
    logic [63:0] pc_q;
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pc_q <= START_PC;
        end else if (trap_in) begin
            pc_q <= TRAP_VECTOR;
        end else if (redirect_valid_in) begin
            pc_q <= redirect_target_in;
        end else if (sequential_valid_in) begin
            pc_q <= pc_q + 64'h4;
        end
    end
    assign pc_out = pc_q;
    // no delay slot, so next pc is always the following word
    assign npc_out = pc_q + 64'h4;
endmodule : fetch_trap_model

// ===== tb_top.sv
/*
 self-checking bench for the compare-branch unit: issue and register tests.
 assumes the fetch model supplies pc and next pc; 20 MHz core clock.
*/
`timescale 1ns/1ps
module tb_top;
    import cbu_pkg::*;
    localparam logic [3:0] RED = 4'h1;
    localparam logic [3:0] SEQ = 4'h2;
    localparam logic [3:0] ILL = 4'h4;
    localparam logic [3:0] CTT = 4'h8;
    logic core_clk_in = 1'b0, resetn_in = 1'b0, issue_valid = 1'b0;
    branch_fields_type fields = '0;
    logic [63:0] first_op = '0, second_op = '0, pc_w, npc_w, target, saved_pc, saved_npc, trap_pc, trap_npc;
    logic [2:0] trap_level = 3'h5, saved_level;
    logic redirect_valid, seq_valid, illegal_trap, ctt_trap, irq, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] taken_map = 16'hFE00;
    int n_fail, comparisons, cycles;

    compare_branch_unit dut_u (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .issue_valid_in(issue_valid),
        .fields_in(fields), .pc_in(pc_w), .npc_in(npc_w), .first_operand_in(first_op),
        .second_operand_in(second_op), .trap_level_in(trap_level), .redirect_valid_out(redirect_valid),
        .redirect_target_out(target), .sequential_valid_out(seq_valid), .illegal_trap_out(illegal_trap),
        .ctt_trap_out(ctt_trap), .trap_saved_pc_out(saved_pc), .trap_saved_next_pc_out(saved_npc),
        .trap_level_out(saved_level), .irq_out(irq), .axi_awvalid_in(awvalid), .axi_awaddr_in(awaddr),
        .axi_awready_out(awready), .axi_wvalid_in(wvalid), .axi_wdata_in(wdata), .axi_wstrb_in(wstrb),
        .axi_wready_out(wready), .axi_bvalid_out(bvalid), .axi_bresp_out(bresp), .axi_bready_in(bready),
        .axi_arvalid_in(arvalid), .axi_araddr_in(araddr), .axi_arready_out(arready),
        .axi_rvalid_out(rvalid), .axi_rdata_out(rdata), .axi_rresp_out(rresp), .axi_rready_in(rready)
    );
    fetch_trap_model model_u (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .redirect_valid_in(redirect_valid),
        .redirect_target_in(target), .sequential_valid_in(seq_valid), .trap_in(illegal_trap | ctt_trap),
        .pc_out(pc_w), .npc_out(npc_w)
    );

    initial begin
        forever #25 core_clk_in = ~core_clk_in;
    end
    // far above the hundred or so cycles the sequence needs
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge core_clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge core_clk_in);
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk_in); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk_in); while (!arready);
        arvalid <= 1'b0;
        do @(posedge core_clk_in); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    // one instruction; outcome is {ctt, illegal, sequential, redirect}
    task automatic issue(input logic [3:0] cond, input logic [9:0] disp, input logic wide, input logic imm,
                         input logic [4:0] imm5, input logic [63:0] a, input logic [63:0] b, input logic [3:0] exp);
        logic [63:0] pc_now;
        logic [63:0] npc_now;
        @(posedge core_clk_in);
        issue_valid <= 1'b1;
        // one register named twice reads the same value in both operands
        fields <= {5'h01, (a == b && !imm) ? 5'h01 : 5'h02, disp, cond, wide, imm, imm5};
        first_op <= a;
        second_op <= b;
        @(posedge core_clk_in);
        issue_valid <= 1'b0;
        pc_now = pc_w;
        npc_now = npc_w;
        #1;
        check("outcome", {ctt_trap, illegal_trap, seq_valid, redirect_valid}, exp);
        if (exp == RED) begin
            check("target", target, pc_now + {{52{disp[9]}}, disp, 2'h0});
        end
        if (exp == CTT) begin
            trap_pc = pc_now;
            trap_npc = npc_now;
            check("saved pc", saved_pc, pc_now);
            check("saved npc", saved_npc, npc_now);
            check("saved level", saved_level, trap_level);
        end
    endtask : issue

    initial begin
        repeat (4) @(posedge core_clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            issue(4'(i), 10'h004, 1'b1, 1'b0, 5'h00, 64'h5, 64'h3, (i % 8 == 0) ? ILL : taken_map[i] ? RED : SEQ);
        end
        issue(COND_LT, 10'h010, 1'b0, 1'b0, 5'h00, 64'h8000_0000, 64'h1, RED);
        issue(COND_LT, 10'h010, 1'b1, 1'b0, 5'h00, 64'h8000_0000, 64'h1, SEQ);
        issue(COND_EQ, 10'h3FF, 1'b0, 1'b0, 5'h00, 64'h7_0000_0009, 64'h9, RED);
        issue(COND_EQ, 10'h3FF, 1'b1, 1'b0, 5'h00, 64'h7_0000_0009, 64'h9, SEQ);
        issue(COND_EQ, 10'h008, 1'b1, 1'b1, 5'h1F, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, RED);
        issue(COND_EQ, 10'h008, 1'b1, 1'b0, 5'h1F, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0, SEQ);
        issue(COND_EQ, 10'h008, 1'b1, 1'b1, 5'h00, 64'h0, 64'h5, RED);
        issue(COND_EQ, 10'h200, 1'b1, 1'b0, 5'h00, 64'h1234, 64'h1234, RED);
        issue(COND_EQ, 10'h1FF, 1'b0, 1'b0, 5'h00, 64'h1234, 64'h1234, RED);
        axi_write(OFS_CONTROL, 32'h1, resp);
        check("control resp", resp, RESP_OKAY);
        issue(COND_EQ, 10'h020, 1'b1, 1'b0, 5'h00, 64'h1, 64'h1, CTT);
        issue(COND_NE, 10'h020, 1'b1, 1'b0, 5'h00, 64'h1, 64'h1, SEQ);
        axi_write(OFS_LEVEL_SELECT, 32'h5, resp);
        axi_read(OFS_SAVED_PC_LO, rd, resp);
        check("saved pc lo", rd, trap_pc[31:0]);
        axi_read(OFS_SAVED_NPC_HI, rd, resp);
        check("saved npc hi", rd, trap_npc[63:32]);
        axi_write(OFS_CONTROL, 32'h0, resp);
        axi_read(OFS_STATUS, rd, resp);
        check("status", rd, 32'h7);
        check("irq masked", irq, 1'b0);
        axi_write(OFS_MASK, 32'h1, resp);
        @(posedge core_clk_in);
        check("irq", irq, 1'b1);
        axi_write(OFS_STATUS, 32'h1, resp);
        @(posedge core_clk_in);
        check("irq cleared", irq, 1'b0);
        axi_read(OFS_STATUS, rd, resp);
        check("status cleared", rd, 32'h6);
        wstrb <= 4'h0;
        axi_write(OFS_MASK, 32'h0, resp);
        check("no strobe resp", resp, RESP_OKAY);
        wstrb <= 4'hF;
        axi_read(OFS_MASK, rd, resp);
        check("no strobe mask", rd, 32'h1);
        axi_read(8'h40, rd, resp);
        check("unmapped read", resp, RESP_SLVERR);
        axi_write(8'h44, 32'h1, resp);
        check("unmapped write", resp, RESP_SLVERR);
        end_sim();
    end
endmodule : tb_top
